/* src/mpio_port.v */
// masked parallel i/o port with avalon-mm register access
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`include "mpio_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module mpio_port #(
   parameter NOUT       = 12,           // output lines
   parameter NIN        = 5,            // input lines
   parameter CYC_PER_MS = `MPIO_MS_NS / `MPIO_CLK_PERIOD_NS // cycles per ms
) (
   input  wire            ref_clk_in,            // 250 MHz clock
   input  wire            reset_in,              // sync reset, active high
   input  wire [7:0]      avs_address_in,        // byte address
   input  wire            avs_read_in,           // read request
   input  wire            avs_write_in,          // write request
   input  wire [3:0]      avs_byteenable_in,     // byte lanes
   input  wire [31:0]     avs_writedata_in,      // write data
   output reg  [31:0]     avs_readdata_out,      // read data
   output wire            avs_waitrequest_out,   // stall
   input  wire [NIN-1:0]  din_in,                // input lines, line n at bit n-1
   output reg  [NOUT-1:0] dout_out               // output lines, line n at bit n-1
);
   localparam CW = 26;

   // inclusive index range to line mask, indices from 1
   function [15:0] range_mask;
      input [3:0] lo;
      input [3:0] hi;
      integer k;
      begin
         range_mask = 16'h0000;
         for (k = 0; k < 16; k = k + 1) begin
            if ((k + 1 >= lo) && (k + 1 <= hi))
               range_mask[k] = 1'b1;
         end
      end
   endfunction

   // byte-enable merge of a write into a word
   function [31:0] be_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  be;
      integer b;
      begin
         be_merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b])
               be_merge[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
   endfunction

   reg  [NOUT-1:0] out_mask_q;
   reg  [15:0]     out_range_q;
   reg  [15:0]     delay_q;
   reg  [NIN-1:0]  in_mask_q;
   reg  [15:0]     in_range_q;
   reg  [NOUT-1:0] revert_q;
   reg  [NOUT-1:0] dout_d;
   reg             ack_q;
   reg  [31:0]     rdata_d;
   reg  [31:0]     merged;
   wire            req;
   wire            acc_wr;
   wire            cmd_go;
   wire            cmd_state;
   wire            cmd_range;
   wire [NOUT-1:0] hit;
   wire [NOUT-1:0] busy;
   wire [NOUT-1:0] expire;
   wire [NIN-1:0]  in_rng;
   wire [NIN-1:0]  masked_in;
   wire [2:0]      single_idx;
   wire            single_bit;
   wire [CW-1:0]   delay_ms;
   wire            ms_tick;
   wire [15:0]     out_rng_mask;
   wire [15:0]     in_rng_mask;
   localparam [9:0] MS_PER_SEC = `MPIO_MS_PER_SEC;

   // bus handshake: one wait cycle per access
   assign req                 = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign acc_wr              = avs_write_in & ack_q;

   always @(posedge ref_clk_in) begin
      if (reset_in)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end

   // command decode from the command register write
   assign cmd_go    = acc_wr && (avs_address_in == `MPIO_OFS_CMD) && avs_byteenable_in[0];
   assign cmd_state = avs_writedata_in[`MPIO_CMD_STATE_BIT];
   assign cmd_range = avs_writedata_in[`MPIO_CMD_RANGE_BIT];

   // [R5] range selects lines lo..hi
   // [R8] mask selects lines by bit
   assign out_rng_mask =
      range_mask(out_range_q[`MPIO_RNG_LO_LSB +: 4], out_range_q[`MPIO_RNG_HI_LSB +: 4]);
   assign hit = cmd_range ? out_rng_mask[NOUT-1:0] : out_mask_q;

   // [R7] seconds scaled to millisecond ticks, fits in cw bits
   assign delay_ms = {{(CW-16){1'b0}}, delay_q} * {{(CW-10){1'b0}}, MS_PER_SEC};

   mpio_ms_tick #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_tick (
      .ref_clk_in (ref_clk_in),
      .reset_in   (reset_in),
      .tick_out   (ms_tick)
   );

   // one reversal timer per output line
   genvar g;
   generate
      for (g = 0; g < NOUT; g = g + 1) begin : g_line
         mpio_line_timer #(
            .CW (CW)
         ) u_tmr (
            .ref_clk_in (ref_clk_in),
            .reset_in   (reset_in),
            .load_in    (cmd_go & hit[g]),
            .ms_in      (delay_ms),
            .tick_in    (ms_tick),
            .busy_out   (busy[g]),
            .expire_out (expire[g])
         );
      end
   endgenerate

   // next output levels
   always @* begin
      // [R4] untouched lines keep level
      dout_d = dout_out;
      if (cmd_go) begin
         // [R9] all selected lines together
         dout_d = (dout_out & ~hit) | ({NOUT{cmd_state}} & hit);
         // [R6] revert only expired, unhit lines
         dout_d = (dout_d & ~(expire & ~hit)) | (revert_q & expire & ~hit);
      end else begin
         // [R6] drive opposite level on expiry
         dout_d = (dout_out & ~expire) | (revert_q & expire);
      end
   end

   // [R3] registered output lines
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         // [R12] outputs low after reset
         dout_out <= `MPIO_RST_OUT;
         revert_q <= `MPIO_RST_OUT;
      end else begin
         dout_out <= dout_d;
         if (cmd_go)
            revert_q <= (revert_q & ~hit) | ({NOUT{~cmd_state}} & hit);
      end
   end

   // configuration registers
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         out_mask_q  <= `MPIO_RST_OUT_MASK;
         out_range_q <= `MPIO_RST_RANGE;
         delay_q     <= `MPIO_RST_DELAY;
         in_mask_q   <= `MPIO_RST_IN_MASK;
         in_range_q  <= `MPIO_RST_RANGE;
      end else if (acc_wr) begin
         case (avs_address_in)
            `MPIO_OFS_OUT_MASK: begin
               out_mask_q <= merged[NOUT-1:0];
            end
            `MPIO_OFS_OUT_RANGE: begin
               out_range_q <= merged[15:0];
            end
            `MPIO_OFS_DELAY: begin
               delay_q <= merged[15:0];
            end
            `MPIO_OFS_IN_MASK: begin
               in_mask_q <= merged[NIN-1:0];
            end
            `MPIO_OFS_IN_RANGE: begin
               in_range_q <= merged[15:0];
            end
            default: begin
               delay_q <= delay_q;
            end
         endcase
      end
   end

   // current register value merged with the write
   always @* begin
      case (avs_address_in)
         `MPIO_OFS_OUT_MASK:  merged = {{(32-NOUT){1'b0}}, out_mask_q};
         `MPIO_OFS_OUT_RANGE: merged = {16'h0000, out_range_q};
         `MPIO_OFS_DELAY:     merged = {16'h0000, delay_q};
         `MPIO_OFS_IN_MASK:   merged = {{(32-NIN){1'b0}}, in_mask_q};
         `MPIO_OFS_IN_RANGE:  merged = {16'h0000, in_range_q};
         default:             merged = 32'h0000_0000;
      endcase
      merged = be_merge(merged, avs_writedata_in, avs_byteenable_in);
   end

   // input sampling
   // [R1] all selected lines sampled together
   // [R2] unselected lines read zero
   assign masked_in  = din_in & in_mask_q;
   // [R10] range packed in place into in_rng, which no register reads back; single as 0 or 1
   assign in_rng_mask =
      range_mask(in_range_q[`MPIO_RNG_LO_LSB +: 4], in_range_q[`MPIO_RNG_HI_LSB +: 4]);
   assign in_rng     = din_in & in_rng_mask[NIN-1:0];
   assign single_idx = in_range_q[`MPIO_RNG_LO_LSB +: 3] - 3'h1;
   assign single_bit = (in_range_q[`MPIO_RNG_LO_LSB +: 4] >= 4'h1) &&
                       (in_range_q[`MPIO_RNG_LO_LSB +: 4] <= NIN) && din_in[single_idx];

   // read mux, unmapped reads zero
   always @* begin
      case (avs_address_in)
         `MPIO_OFS_OUT_MASK:  rdata_d = {{(32-NOUT){1'b0}}, out_mask_q};
         `MPIO_OFS_OUT_RANGE: rdata_d = {16'h0000, out_range_q};
         `MPIO_OFS_DELAY:     rdata_d = {16'h0000, delay_q};
         `MPIO_OFS_OUT_STATE: rdata_d = {{(32-NOUT){1'b0}}, dout_out};
         `MPIO_OFS_IN_MASK:   rdata_d = {{(32-NIN){1'b0}}, in_mask_q};
         `MPIO_OFS_IN_RANGE:  rdata_d = {16'h0000, in_range_q};
         `MPIO_OFS_IN_BIN:    rdata_d = {{(32-NIN){1'b0}}, masked_in};
         `MPIO_OFS_IN_SINGLE: rdata_d = {31'h0000_0000, single_bit};
         `MPIO_OFS_PENDING:   rdata_d = {{(32-NOUT){1'b0}}, busy};
         default:             rdata_d = 32'h0000_0000;
      endcase
   end

   // read data captured in the wait cycle, held for the accept edge
   always @(posedge ref_clk_in) begin
      if (reset_in)
         avs_readdata_out <= 32'h0000_0000;
      else if (avs_read_in && !ack_q)
         avs_readdata_out <= rdata_d;
   end
endmodule // mpio_port
`default_nettype wire

/* src/mpio_defs.vh */
// constants of the masked parallel i/o port
// Behaviour
// [R1] A masked input read samples every selected input line in one cycle and returns them packed, line n at bit n-1.
// [R2] Input lines whose mask bit is clear read as zero, so the result is the inputs ANDed with the mask.
// [R3] There are twelve output lines, indexed 1 to 12, each holding a registered level.
// [R4] A single-line output command drives the requested 0 or 1 onto the addressed line and leaves all others alone.
// [R5] An output command may address an inclusive index range, and every line from low to high index takes the state at once.
// [R6] With a delay, the affected lines hold the state for that period and then go to the opposite level, only those lines.
// [R7] The delay counts in seconds, and without a delay the state stays until another command changes it.
// [R8] A masked output command applies the state only to lines whose bit is set in the 12-bit mask, bit n-1 for line n.
// [R9] All lines selected by a masked output command change in the same clock cycle.
// [R10] There are five input lines, indexed 1 to 5, readable singly as 0 or 1 or as a contiguous range packed in place; the code reads back no range.
// [R11] A new command that reaches a line with a pending reversal cancels it, and the new state and delay apply.
// [R12] After reset all twelve outputs are low and no delay timer is pending.
`ifndef MPIO_DEFS_VH
`define MPIO_DEFS_VH

// register byte offsets
`define MPIO_OFS_OUT_MASK  8'h00
`define MPIO_OFS_OUT_RANGE 8'h04
`define MPIO_OFS_DELAY     8'h08
`define MPIO_OFS_CMD       8'h0C
`define MPIO_OFS_OUT_STATE 8'h10
`define MPIO_OFS_IN_MASK   8'h14
`define MPIO_OFS_IN_RANGE  8'h18
`define MPIO_OFS_IN_BIN    8'h1C
`define MPIO_OFS_IN_SINGLE 8'h20
`define MPIO_OFS_PENDING   8'h24

// field positions
`define MPIO_RNG_LO_LSB    0
`define MPIO_RNG_HI_LSB    8
`define MPIO_CMD_STATE_BIT 0
`define MPIO_CMD_RANGE_BIT 1

// reset values
`define MPIO_RST_OUT       12'h000
`define MPIO_RST_OUT_MASK  12'h000
`define MPIO_RST_RANGE     16'h0000
`define MPIO_RST_DELAY     16'h0000
`define MPIO_RST_IN_MASK   5'h1F

// timing
`define MPIO_CLK_PERIOD_NS 4
`define MPIO_MS_NS         1000000
`define MPIO_MS_PER_SEC    1000

`endif

/* src/mpio_ms_tick.v */
// millisecond enable divider for the delay timers
`timescale 1ns/1ns
`default_nettype none
module mpio_ms_tick #(
   parameter CYC_PER_MS = 250000        // clock cycles per millisecond
) (
   input  wire ref_clk_in,              // system clock
   input  wire reset_in,                // sync reset, active high
   output reg  tick_out                 // one-cycle pulse each ms
);
   reg [31:0] cnt_q;

   // free-running divider
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         cnt_q    <= 32'h0000_0000;
         tick_out <= 1'b0;
      end else if (cnt_q == CYC_PER_MS - 1) begin
         cnt_q    <= 32'h0000_0000;
         tick_out <= 1'b1;
      end else begin
         cnt_q    <= cnt_q + 32'h0000_0001;
         tick_out <= 1'b0;
      end
   end
endmodule // mpio_ms_tick
`default_nettype wire

/* src/mpio_line_timer.v */
// per-line timed reversal countdown
`timescale 1ns/1ns
`default_nettype none
module mpio_line_timer #(
   parameter CW = 26                    // width of millisecond count
) (
   input  wire          ref_clk_in,     // system clock
   input  wire          reset_in,       // sync reset, active high
   input  wire          load_in,        // command reaches this line
   input  wire [CW-1:0] ms_in,          // delay in ms, zero = none
   input  wire          tick_in,        // millisecond enable
   output wire          busy_out,       // reversal pending
   output reg           expire_out      // one-cycle pulse at expiry
);
   reg [CW-1:0] rem_q;

   assign busy_out = (rem_q != {CW{1'b0}});

   // load restarts, zero cancels, ticks count down
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         rem_q      <= {CW{1'b0}};
         expire_out <= 1'b0;
      end else if (load_in) begin
         // [R11] newer command replaces pending
         rem_q      <= (ms_in == {CW{1'b0}}) ? {CW{1'b0}} : ms_in + {{(CW-1){1'b0}}, 1'b1};
         expire_out <= 1'b0;
      end else if (tick_in && busy_out) begin
         rem_q      <= rem_q - {{(CW-1){1'b0}}, 1'b1};
         expire_out <= (rem_q == {{(CW-1){1'b0}}, 1'b1});
      end else begin
         expire_out <= 1'b0;
      end
   end
endmodule // mpio_line_timer
`default_nettype wire

/* sim/mpio_port_checker.sv */
// assertions on the pins of the masked parallel i/o port
`timescale 1ns/1ns
`default_nettype none
module mpio_port_checker #(
   parameter NOUT = 12, // output lines
   parameter NIN  = 5   // input lines
) (
   input wire logic            ref_clk_in,          // clock
   input wire logic            reset_in,            // sync reset
   input wire logic [7:0]      avs_address_in,      // address
   input wire logic            avs_read_in,         // read
   input wire logic            avs_write_in,        // write
   input wire logic [3:0]      avs_byteenable_in,   // lanes
   input wire logic [31:0]     avs_writedata_in,    // write data
   input wire logic [31:0]     avs_readdata_out,    // read data
   input wire logic            avs_waitrequest_out, // stall
   input wire logic [NIN-1:0]  din_in,              // input lines
   input wire logic [NOUT-1:0] dout_out             // output lines
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   logic [NOUT-1:0] omask_q; // mirrored line-select mask
   logic [NIN-1:0]  imask_q; // mirrored input mask
   logic            dly_q;   // delay register non-zero
   logic            armed_q; // a timed command was issued
   wire             wa_w = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
   wire             ra_w = avs_read_in & ~avs_waitrequest_out;
   wire             cmd_w = wa_w & (avs_address_in == 8'h0C);
   // mirror of the registers the checks lean on
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         omask_q <= '0;
         imask_q <= '1;
         dly_q   <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if (wa_w && avs_address_in == 8'h00) omask_q <= avs_writedata_in[NOUT-1:0];
         if (wa_w && avs_address_in == 8'h14) imask_q <= avs_writedata_in[NIN-1:0];
         if (wa_w && avs_address_in == 8'h08) dly_q <= |avs_writedata_in[15:0];
         if (cmd_w && dly_q) armed_q <= 1'b1;
      end
   end
   property p_wait;
      (avs_read_in | avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait) else $error("stall lasted past one cycle");
   property p_toggle;
      (avs_read_in | avs_write_in) && !avs_waitrequest_out |=> avs_waitrequest_out || !(avs_read_in | avs_write_in);
   endproperty
   a_toggle: assert property (p_toggle) else $error("second request not stalled");
   property p_inbin;
      ra_w && avs_address_in == 8'h1C |-> avs_readdata_out == 32'($past(din_in) & imask_q);
   endproperty
   a_inbin: assert property (p_inbin) else $error("masked input word wrong");
   property p_outst;
      ra_w && avs_address_in == 8'h10 |-> avs_readdata_out == 32'($past(dout_out));
   endproperty
   a_outst: assert property (p_outst) else $error("output state readback wrong");
   property p_unmapped;
      ra_w && avs_address_in > 8'h24 |-> avs_readdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_mask;
      cmd_w && !avs_writedata_in[1] |=> dout_out == ($past(avs_writedata_in[0]) ?
         ($past(dout_out) | omask_q) : ($past(dout_out) & ~omask_q));
   endproperty
   a_mask: assert property (p_mask) else $error("masked command result wrong");
   property p_reset;
      $fell(reset_in) |-> dout_out == '0 && avs_readdata_out == 32'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not low after reset");
   property p_still;
      !armed_q && !$past(cmd_w) |-> $stable(dout_out);
   endproperty
   a_still: assert property (p_still) else $error("output moved without command");
endmodule // mpio_port_checker
`default_nettype wire

/* sim/mpio_equip_model.sv */
// external equipment model driving the five input lines
`timescale 1ns/1ns
`default_nettype none
module mpio_equip_model (
   input  wire logic       ref_clk_in, // clock
   input  wire logic [4:0] set_in,     // levels asked by the bench
   output var  logic [4:0] lines_out   // levels on the port inputs
);
   initial lines_out = 5'h00;
   // equipment switches its lines just after an edge
   always @(posedge ref_clk_in) begin
      lines_out <= set_in;
   end
endmodule // mpio_equip_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the masked parallel i/o port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        ref_clk_in = 1'b0;     // 250 MHz clock
   logic        reset_in = 1'b1;       // sync reset
   logic [7:0]  addr = 8'h00;          // bus address
   logic        rd = 1'b0;             // read strobe
   logic        wr = 1'b0;             // write strobe
   logic [3:0]  be = 4'hF;             // byte lanes
   logic [31:0] wdata = 32'h0;         // write data
   logic [4:0]  pat = 5'h00;           // input levels asked
   logic [11:0] exp_o = 12'h000;       // expected outputs
   logic [31:0] q;                     // last read value
   int          n_fail = 0;            // mismatches
   int          samples_checked = 0;   // comparisons
   wire  [31:0] rdata;                 // read data
   wire         wreq;                  // stall
   wire  [4:0]  din;                   // input lines
   wire  [11:0] dout;                  // output lines
   always #2 ref_clk_in = ~ref_clk_in;
   mpio_equip_model eq_u (.ref_clk_in(ref_clk_in), .set_in(pat), .lines_out(din));
   mpio_port #(.CYC_PER_MS(10)) dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
      .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .din_in(din), .dout_out(dout));
   // one bus cycle held until the stall drops
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do @(posedge ref_clk_in); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic outc;
      @(negedge ref_clk_in);
      chk("dout", 32'(exp_o), 32'(dout));
   endtask
   task automatic t_reset;
      outc();
      rdc(8'h10, 32'h0);
      rdc(8'h24, 32'h0);
      rdc(8'h14, 32'h1F);
   endtask
   task automatic t_in;
      pat <= 5'h15;
      bus(1'b1, 8'h14, 32'h13);
      rdc(8'h1C, 32'h11);
      bus(1'b1, 8'h14, 32'h1F);
      rdc(8'h1C, 32'h15);
      for (int i = 1; i <= 6; i++) begin
         bus(1'b1, 8'h18, 32'(i));
         rdc(8'h20, (i <= 5) ? 32'(pat[i-1]) : 32'h0);
      end
   endtask
   task automatic t_mask;
      bus(1'b1, 8'h00, 32'h8D6);
      bus(1'b1, 8'h0C, 32'h1);
      exp_o = 12'h8D6;
      outc();
      bus(1'b1, 8'h00, 32'h802);
      bus(1'b1, 8'h0C, 32'h0);
      exp_o = 12'h0D4;
      outc();
      bus(1'b1, 8'h10, 32'hFFF);
      outc();
      // command without lane 0 must not execute
      be <= 4'hE;
      bus(1'b1, 8'h0C, 32'h1);
      be <= 4'hF;
      outc();
      rdc(8'h3C, 32'h0);
   endtask
   task automatic t_range;
      bus(1'b1, 8'h04, 32'h0503);
      bus(1'b1, 8'h0C, 32'h3);
      exp_o = exp_o | 12'h01C;
      outc();
      bus(1'b1, 8'h04, 32'h0404);
      bus(1'b1, 8'h0C, 32'h2);
      exp_o = exp_o & ~12'h008;
      outc();
      bus(1'b1, 8'h04, 32'h0C0C);
      bus(1'b1, 8'h0C, 32'h3);
      exp_o = exp_o | 12'h800;
      outc();
   endtask
   task automatic t_delay;
      bus(1'b1, 8'h00, 32'hFFF);
      bus(1'b1, 8'h0C, 32'h0);
      bus(1'b1, 8'h08, 32'h1);
      bus(1'b1, 8'h00, 32'h00F);
      bus(1'b1, 8'h0C, 32'h1);
      exp_o = 12'h00F;
      outc();
      rdc(8'h24, 32'h00F);
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h00, 32'h001);
      bus(1'b1, 8'h0C, 32'h1);
      rdc(8'h24, 32'h00E);
      repeat (9800) @(posedge ref_clk_in);
      outc();
      repeat (400) @(posedge ref_clk_in);
      exp_o = 12'h001;
      outc();
      rdc(8'h24, 32'h0);
   endtask
   task automatic conclude;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      t_reset();
      t_in();
      t_mask();
      t_range();
      t_delay();
      conclude();
   end
   // watchdog against a hung handshake
   initial begin
      repeat (30000) @(posedge ref_clk_in);
      n_fail++;
      conclude();
   end
endmodule // tb_top
bind mpio_port mpio_port_checker #(.NOUT(NOUT), .NIN(NIN)) chk_u (.ref_clk_in(ref_clk_in),
   .reset_in(reset_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .din_in(din_in), .dout_out(dout_out));
`default_nettype wire
